// >>> hdl/emmc_defines.svh
// register map, field positions, reset values and timing counts of the memory mode block
`ifndef EMMC_DEFINES_SVH
`define EMMC_DEFINES_SVH
// byte offsets of the registers on the bus
`define EMMC_OFS_CONFIG 8'h00
`define EMMC_OFS_PAGE 8'h04
`define EMMC_OFS_STATUS 8'h08
// field positions inside external_memory_config
`define EMMC_CFG_MUX_BIT 4
`define EMMC_CFG_MAP_HI 3
`define EMMC_CFG_MAP_LO 2
`define EMMC_CFG_ALE_HI 1
`define EMMC_CFG_ALE_LO 0
// reset values
`define EMMC_RST_CONFIG 8'h03
`define EMMC_RST_PAGE 8'h00
// writable bits of the config register, the rest read as zero
`define EMMC_CFG_MASK 8'h1f
// on-chip xram size in bytes and its address width
`define EMMC_XRAM_BYTES 17'h01000
`define EMMC_XRAM_AW 12
// strobe phase length minus one; the read or write strobe stays low 3 cycles
`define EMMC_STROBE_CYCLES 2'h2
`endif

// >>> hdl/emmc_pkg.sv
// types shared by the memory mode block
package emmc_pkg;
  // memory map modes
  typedef enum logic [1:0] {
    emmc_map_internal = 2'h0,
    emmc_map_split_nobank = 2'h1,
    emmc_map_split_bank = 2'h2,
    emmc_map_external = 2'h3
  } emmc_map_t;
  // access sequencer states, one-hot
  typedef enum logic [5:0] {
    emmc_idle = 6'h01,
    emmc_onchip = 6'h02,
    emmc_ale_high = 6'h04,
    emmc_ale_low = 6'h08,
    emmc_strobe = 6'h10,
    emmc_finish = 6'h20
  } emmc_state_t;
endpackage

// >>> hdl/emmc_phase_timer.sv
// down-counter that times one phase of an off-chip access
`timescale 1ns/10ps
`default_nettype none
module emmc_phase_timer (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [1:0] length,
  output logic last
);
  logic [1:0] count; // cycles left after this one
  logic [1:0] next_count;
  // reload on a phase start, else count down to zero
  always_comb begin
    if (load) begin
      next_count = length;
    end else if (count != 2'h0) begin
      next_count = count - 2'h1;
    end else begin
      next_count = count;
    end
  end
  // register the count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count <= 2'h0;
    end else begin
      count <= next_count;
    end
  end
  // last cycle of the running phase; independent of load so no loop through the caller
  assign last = (count == 2'h0);
endmodule
`default_nettype wire

// >>> hdl/emmc_top.sv
// external data memory mode controller with an ahb-lite register slave
//
// How it works
// - split modes: below 4 kB on-chip, else off-chip
// - mode 01 8-bit off-chip: upper byte released
// - mode 10 8-bit: page drives upper pins
// - mode 11: everything off-chip, xram hidden
// - pulse width only matters in multiplexed mode
// - width codes give 1 to 4 cycles
// - mux select 0 multiplexed, 1 separate
// - multiplexed: low address and data share pins
// - multiplexed: block drives the latch strobe
// - strobe high while low address shown
// - after strobe falls, data with read/write
// - non-multiplexed: address and data on separate pins
// - mode 00: all on-chip, addresses alias
// - 8-bit access: page gives the high byte
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "emmc_defines.svh"
module emmc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // cpu external move request
  input wire logic cpu_req,
  input wire logic cpu_short,
  input wire logic cpu_write,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cpu_ack,
  output logic [7:0] cpu_rdata,
  // on-chip xram
  output logic xram_en,
  output logic xram_we,
  output logic [11:0] xram_addr,
  output logic [7:0] xram_wdata,
  input wire logic [7:0] xram_rdata,
  // off-chip pins
  output logic [7:0] addr_hi_out,
  output logic addr_hi_oe_n,
  output logic [7:0] addr_lo_out,
  output logic addr_lo_oe_n,
  output logic [7:0] ad_out,
  output logic ad_oe_n,
  input wire logic [7:0] ad_in,
  output logic address_latch_strobe,
  output logic read_strobe_n,
  output logic write_strobe_n
);
  import emmc_pkg::*;

  // decide whether an access goes off-chip for a given map mode
  function automatic logic goes_off_chip(input emmc_map_t mode, input logic [15:0] ea);
    logic off;
    off = 1'b0;
    unique case (mode)
      emmc_map_internal: off = 1'b0;
      emmc_map_external: off = 1'b1;
      emmc_map_split_nobank, emmc_map_split_bank: begin
        off = ({1'b0, ea} >= `EMMC_XRAM_BYTES);
      end
    endcase
    return off;
  endfunction

  // ---------------- register slave ----------------
  logic [7:0] external_memory_config; // mux, map and pulse width fields
  logic [7:0] xram_page_select; // high byte for 8-bit moves
  logic [7:0] next_config;
  logic [7:0] next_page;
  logic wr_pend; // write data phase pending
  logic [7:0] wr_ofs; // offset of the pending write
  logic next_wr_pend;
  logic [7:0] next_wr_ofs;
  logic [31:0] next_hrdata;
  logic addr_phase; // valid transfer in address phase
  logic [31:0] status_word; // live block state for reads

  assign addr_phase = hsel && htrans[1] && hready;

  // decode writes, answer reads one cycle after the address phase
  always_comb begin
    next_config = external_memory_config;
    next_page = xram_page_select;
    next_wr_pend = addr_phase && hwrite;
    next_wr_ofs = haddr[7:0];
    next_hrdata = hrdata;
    if (wr_pend) begin
      if (wr_ofs == `EMMC_OFS_CONFIG) begin
        next_config = hwdata[7:0] & `EMMC_CFG_MASK;
      end else if (wr_ofs == `EMMC_OFS_PAGE) begin
        next_page = hwdata[7:0];
      end
    end
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        `EMMC_OFS_CONFIG: next_hrdata = {24'h000000, external_memory_config};
        `EMMC_OFS_PAGE: next_hrdata = {24'h000000, xram_page_select};
        `EMMC_OFS_STATUS: next_hrdata = status_word;
        default: next_hrdata = 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // register the slave state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      external_memory_config <= `EMMC_RST_CONFIG;
      xram_page_select <= `EMMC_RST_PAGE;
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      external_memory_config <= next_config;
      xram_page_select <= next_page;
      wr_pend <= next_wr_pend;
      wr_ofs <= next_wr_ofs;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1; // zero wait states, always okay
      hresp <= 1'b0;
    end
  end

  // config fields
  logic cfg_separate; // 1 selects non-multiplexed pins
  emmc_map_t cfg_map;
  logic [1:0] cfg_ale;
  assign cfg_separate = external_memory_config[`EMMC_CFG_MUX_BIT];
  assign cfg_map = emmc_map_t'(external_memory_config[`EMMC_CFG_MAP_HI:`EMMC_CFG_MAP_LO]);
  assign cfg_ale = external_memory_config[`EMMC_CFG_ALE_HI:`EMMC_CFG_ALE_LO];

  // ---------------- pin input synchroniser ----------------
  logic [7:0] ad_meta; // first stage, read only by ad_sync
  logic [7:0] ad_sync;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ad_meta <= 8'h00;
      ad_sync <= 8'h00;
    end else begin
      ad_meta <= ad_in;
      ad_sync <= ad_meta;
    end
  end

  // ---------------- access sequencer ----------------
  emmc_state_t state;
  emmc_state_t next_state;
  logic [15:0] eff_addr; // effective address of the request
  logic req_off; // request goes off-chip
  logic hold_mux; // access started in multiplexed mode
  logic hold_write; // access is a write
  logic hold_last_off; // last access went off-chip
  logic [7:0] hold_wdata;
  logic next_hold_mux;
  logic next_hold_write;
  logic next_hold_last_off;
  logic [7:0] next_hold_wdata;
  logic tmr_load; // start a timed phase
  logic [1:0] tmr_len; // phase length minus one
  logic tmr_last; // timed phase ends this cycle
  // registered pin and port next values
  logic next_cpu_ack;
  logic [7:0] next_cpu_rdata;
  logic next_xram_en;
  logic next_xram_we;
  logic [11:0] next_xram_addr;
  logic [7:0] next_xram_wdata;
  logic [7:0] next_addr_hi_out;
  logic next_addr_hi_oe_n;
  logic [7:0] next_addr_lo_out;
  logic next_addr_lo_oe_n;
  logic [7:0] next_ad_out;
  logic next_ad_oe_n;
  logic next_ale;
  logic next_rd_n;
  logic next_wr_n;

  assign eff_addr = cpu_short ? {xram_page_select, cpu_addr[7:0]} : cpu_addr;
  assign req_off = goes_off_chip(cfg_map, eff_addr);
  assign status_word = {28'h0000000, hold_last_off, hold_mux, 1'b0, state != emmc_idle};

  // phase timer for latch strobe halves and read/write strobe
  emmc_phase_timer u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .length(tmr_len),
    .last(tmr_last)
  );

  // next state and next pin values
  always_comb begin
    next_state = state;
    next_hold_mux = hold_mux;
    next_hold_write = hold_write;
    next_hold_last_off = hold_last_off;
    next_hold_wdata = hold_wdata;
    tmr_load = 1'b0;
    tmr_len = cfg_ale;
    next_cpu_ack = 1'b0;
    next_cpu_rdata = cpu_rdata;
    next_xram_en = 1'b0;
    next_xram_we = 1'b0;
    next_xram_addr = xram_addr;
    next_xram_wdata = xram_wdata;
    next_addr_hi_out = addr_hi_out;
    next_addr_hi_oe_n = addr_hi_oe_n;
    next_addr_lo_out = addr_lo_out;
    next_addr_lo_oe_n = addr_lo_oe_n;
    next_ad_out = ad_out;
    next_ad_oe_n = ad_oe_n;
    next_ale = 1'b0;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    unique case (state)
      emmc_idle: begin
        if (cpu_req && !cpu_ack) begin // a request still held at its ack is not taken again
          next_hold_write = cpu_write;
          next_hold_wdata = cpu_wdata;
          next_hold_mux = !cfg_separate;
          next_hold_last_off = req_off;
          if (!req_off) begin
            // on-chip: upper bits fold away so addresses alias
            next_xram_en = 1'b1;
            next_xram_we = cpu_write;
            next_xram_addr = eff_addr[`EMMC_XRAM_AW-1:0];
            next_xram_wdata = cpu_wdata;
            next_state = emmc_onchip;
          end else begin
            next_addr_hi_out = eff_addr[15:8];
            // 8-bit moves outside mode 10 leave the upper byte to the port latches
            if (cpu_short && (cfg_map != emmc_map_split_bank)) begin
              next_addr_hi_oe_n = 1'b1;
            end else begin
              next_addr_hi_oe_n = 1'b0;
            end
            if (!cfg_separate) begin
              // first phase: low address on the shared pins, strobe high
              next_ad_out = eff_addr[7:0];
              next_ad_oe_n = 1'b0;
              next_addr_lo_oe_n = 1'b1;
              next_ale = 1'b1;
              tmr_load = 1'b1;
              tmr_len = cfg_ale;
              next_state = emmc_ale_high;
            end else begin
              // separate pins: address and data never share
              next_addr_lo_out = eff_addr[7:0];
              next_addr_lo_oe_n = 1'b0;
              next_ad_out = cpu_wdata;
              next_ad_oe_n = !cpu_write;
              next_rd_n = cpu_write;
              next_wr_n = !cpu_write;
              tmr_load = 1'b1;
              tmr_len = `EMMC_STROBE_CYCLES;
              next_state = emmc_strobe;
            end
          end
        end
      end
      emmc_onchip: begin
        // xram read data is taken in the cycle its enable is high
        next_cpu_rdata = xram_rdata;
        next_cpu_ack = 1'b1;
        next_state = emmc_idle;
      end
      emmc_ale_high: begin
        if (tmr_last) begin
          // strobe falls, latch freezes the low address
          tmr_load = 1'b1;
          tmr_len = cfg_ale;
          next_state = emmc_ale_low;
        end else begin
          next_ale = 1'b1;
        end
      end
      emmc_ale_low: begin
        if (tmr_last) begin
          // second phase: data on the shared pins with the strobe
          next_ad_out = hold_wdata;
          next_ad_oe_n = !hold_write;
          next_rd_n = hold_write;
          next_wr_n = !hold_write;
          tmr_load = 1'b1;
          tmr_len = `EMMC_STROBE_CYCLES;
          next_state = emmc_strobe;
        end
      end
      emmc_strobe: begin
        if (tmr_last) begin
          // synchronised pin data is valid by the final strobe cycle
          next_cpu_rdata = hold_write ? cpu_rdata : ad_sync;
          next_state = emmc_finish;
        end else begin
          next_rd_n = read_strobe_n;
          next_wr_n = write_strobe_n;
        end
      end
      emmc_finish: begin
        // release the pins and answer the cpu
        next_ad_oe_n = 1'b1;
        next_addr_hi_oe_n = 1'b1;
        next_addr_lo_oe_n = 1'b1;
        next_cpu_ack = 1'b1;
        next_state = emmc_idle;
      end
      default: begin
        next_state = emmc_idle; // recover from an illegal code
      end
    endcase
  end

  // register sequencer state and every pin
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= emmc_idle;
      hold_mux <= 1'b0;
      hold_write <= 1'b0;
      hold_last_off <= 1'b0;
      hold_wdata <= 8'h00;
      cpu_ack <= 1'b0;
      cpu_rdata <= 8'h00;
      xram_en <= 1'b0;
      xram_we <= 1'b0;
      xram_addr <= 12'h000;
      xram_wdata <= 8'h00;
      addr_hi_out <= 8'h00;
      addr_hi_oe_n <= 1'b1;
      addr_lo_out <= 8'h00;
      addr_lo_oe_n <= 1'b1;
      ad_out <= 8'h00;
      ad_oe_n <= 1'b1;
      address_latch_strobe <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      state <= next_state;
      hold_mux <= next_hold_mux;
      hold_write <= next_hold_write;
      hold_last_off <= next_hold_last_off;
      hold_wdata <= next_hold_wdata;
      cpu_ack <= next_cpu_ack;
      cpu_rdata <= next_cpu_rdata;
      xram_en <= next_xram_en;
      xram_we <= next_xram_we;
      xram_addr <= next_xram_addr;
      xram_wdata <= next_xram_wdata;
      addr_hi_out <= next_addr_hi_out;
      addr_hi_oe_n <= next_addr_hi_oe_n;
      addr_lo_out <= next_addr_lo_out;
      addr_lo_oe_n <= next_addr_lo_oe_n;
      ad_out <= next_ad_out;
      ad_oe_n <= next_ad_oe_n;
      address_latch_strobe <= next_ale;
      read_strobe_n <= next_rd_n;
      write_strobe_n <= next_wr_n;
    end
  end
endmodule
`default_nettype wire

// >>> verification/emmc_top_chk.sv
// pin-level assertions for the memory mode block
`timescale 1ns/10ps
`default_nettype none
module emmc_top_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cpu_ack,
  input wire logic xram_en,
  input wire logic ad_oe_n,
  input wire logic addr_lo_oe_n,
  input wire logic address_latch_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // the register slave never stalls or errors
  a_bus_okay:
    assert property (hreadyout && !hresp) else $error("bus stalled or errored");
  a_ale_shows_addr:
    assert property (address_latch_strobe |-> !ad_oe_n && read_strobe_n && write_strobe_n)
    else $error("latch strobe without low address");
  a_sep_no_ale:
    assert property (!addr_lo_oe_n |-> !address_latch_strobe) else $error("strobe in separate mode");
  a_read_release:
    assert property (!read_strobe_n |-> ad_oe_n) else $error("pins driven during read");
  a_write_data:
    assert property (!write_strobe_n |-> !ad_oe_n) else $error("no data during write");
  a_strobe_run:
    assert property ($fell(read_strobe_n) |=> !read_strobe_n [*2] ##1 read_strobe_n ##1
      (read_strobe_n && cpu_ack))
    else $error("read strobe length wrong");
  a_ale_phase:
    assert property ($fell(address_latch_strobe) |-> ##[1:4] !(read_strobe_n && write_strobe_n))
    else $error("low phase too long");
  a_ale_width:
    assert property ($rose(address_latch_strobe) |-> ##[1:4] !address_latch_strobe)
    else $error("latch strobe too long");
  a_onchip_quiet:
    assert property (xram_en |-> ad_oe_n && read_strobe_n && write_strobe_n)
    else $error("pins active on on-chip access");
  a_xram_ack:
    assert property (xram_en |=> cpu_ack) else $error("on-chip ack late");
  // pins come free together with the acknowledge
  a_ack_release:
    assert property (cpu_ack |-> ad_oe_n && read_strobe_n) else $error("pins held at ack");
  c_mux: cover property ($fell(address_latch_strobe));
  c_onchip: cover property (xram_en);
  c_sep_write: cover property (!write_strobe_n && !addr_lo_oe_n);
endmodule
bind emmc_top emmc_top_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .hreadyout(hreadyout), .hresp(hresp), .cpu_ack(cpu_ack), .xram_en(xram_en),
  .ad_oe_n(ad_oe_n), .addr_lo_oe_n(addr_lo_oe_n),
  .address_latch_strobe(address_latch_strobe),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));
`default_nettype wire

// >>> verification/emmc_sram_model.sv
// external sram behind a transparent address latch
`timescale 1ns/10ps
`default_nettype none
module emmc_sram_model (
  input wire logic sys_clk,
  input wire logic mux_mode,
  input wire logic [7:0] port_hi,
  input wire logic [7:0] addr_hi_out,
  input wire logic addr_hi_oe_n,
  input wire logic [7:0] addr_lo_out,
  input wire logic [7:0] ad_out,
  input wire logic address_latch_strobe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic ad_oe_n,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:65535]; // memory array
  logic [7:0] latch_q = 8'h00; // low address latch
  logic [7:0] last = 8'h00; // last byte driven
  logic [15:0] addr; // resolved address
  // latch passes while strobe high, holds after it falls
  always @* if (address_latch_strobe) latch_q = ad_out;
  // released upper pins show the port latch contents
  assign addr = {addr_hi_oe_n ? port_hi : addr_hi_out, mux_mode ? addr_lo_out : latch_q};
  // store on write strobe, remember last read byte
  always @(posedge sys_clk) begin
    if (!write_strobe_n && !ad_oe_n) mem[addr] <= ad_out;
    if (!read_strobe_n) last <= mem[addr];
  end
  // released bus shows the inverse of the last byte
  assign ad_in = read_strobe_n ? ~last : mem[addr];
endmodule
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the memory mode block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import emmc_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic cpu_req = 1'b0;
  logic cpu_short = 1'b0;
  logic cpu_write = 1'b0;
  logic [15:0] cpu_addr = 16'h0;
  logic [7:0] cpu_wdata = 8'h0;
  logic cpu_ack;
  logic [7:0] cpu_rdata;
  logic xram_en, xram_we;
  logic [11:0] xram_addr;
  logic [7:0] xram_wdata, xram_q, ad_in, addr_hi_out, addr_lo_out, ad_out;
  logic [7:0] xmem [0:4095];
  logic addr_hi_oe_n, addr_lo_oe_n, ad_oe_n, ale, rd_n, wr_n;
  logic mux_mode = 1'b1; // separate pins in the sram model
  logic [7:0] port_hi = 8'h00; // port latch value on released pins
  int failures = 0;
  int n_tests = 0;
  int hi_len, lo_len, xram_hits;
  logic lo_done, hi_drv;
  logic [7:0] hi_seen, d;
  logic [31:0] r;
  always #20 sys_clk = ~sys_clk;
  emmc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_req(cpu_req),
    .cpu_short(cpu_short), .cpu_write(cpu_write), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .xram_en(xram_en),
    .xram_we(xram_we), .xram_addr(xram_addr), .xram_wdata(xram_wdata),
    .xram_rdata(xram_q), .addr_hi_out(addr_hi_out), .addr_hi_oe_n(addr_hi_oe_n),
    .addr_lo_out(addr_lo_out), .addr_lo_oe_n(addr_lo_oe_n), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .ad_in(ad_in), .address_latch_strobe(ale),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n));
  emmc_sram_model u_sram (.sys_clk(sys_clk), .mux_mode(mux_mode), .port_hi(port_hi),
    .addr_hi_out(addr_hi_out), .addr_hi_oe_n(addr_hi_oe_n), .addr_lo_out(addr_lo_out),
    .ad_out(ad_out), .address_latch_strobe(ale), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .ad_oe_n(ad_oe_n), .ad_in(ad_in));
  // on-chip xram: write on the clock, read data follows the address
  assign xram_q = xmem[xram_addr];
  always @(posedge sys_clk) begin
    if (xram_en && xram_we) xmem[xram_addr] <= xram_wdata;
  end
  // pin monitor: latch strobe phases, upper byte, on-chip hits
  always @(posedge sys_clk) begin
    if (xram_en) xram_hits++;
    if (!addr_hi_oe_n) begin
      hi_drv = 1'b1;
      hi_seen = addr_hi_out;
    end
    if (ale) hi_len++;
    else if (hi_len != 0 && !lo_done) begin
      if (rd_n && wr_n) lo_len++;
      else lo_done = 1'b1;
    end
  end
  // print the verdict and stop
  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // compare one value
  task automatic chk(input string name, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  // wait for a ready edge, bounded
  task automatic wait_ready();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      failures++;
      end_of_test();
    end
  endtask
  // one single-word bus transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  // one external move, byte wide
  task automatic cpu_acc(input logic sh, wr, input logic [15:0] a, input logic [7:0] wd,
                         output logic [7:0] rd);
    int i;
    hi_len = 0;
    lo_len = 0;
    lo_done = 1'b0;
    hi_drv = 1'b0;
    xram_hits = 0;
    @(posedge sys_clk);
    cpu_req <= 1'b1;
    cpu_short <= sh;
    cpu_write <= wr;
    cpu_addr <= a;
    cpu_wdata <= wd;
    for (i = 0; i < 100 && cpu_ack !== 1'b1; i++) @(negedge sys_clk);
    if (cpu_ack !== 1'b1) begin
      failures++;
      end_of_test();
    end
    rd = cpu_rdata;
    @(posedge sys_clk);
    cpu_req <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    ahb(0, 8'h00, 0, r); chk("config reset", r, 32'h03);
    ahb(0, 8'h04, 0, r); chk("page reset", r, 32'h00);
    ahb(1, 8'h00, 32'hff, r);
    ahb(1, 8'h0c, 32'h00, r);
    ahb(0, 8'h00, 0, r); chk("config unused bits", r, 32'h1f);
    ahb(0, 8'h0c, 0, r); chk("unmapped", r, 32'h0);
    // internal only: high addresses alias on-chip
    ahb(1, 8'h00, 32'h00, r);
    cpu_acc(0, 1, 16'h2005, 8'h5a, d); chk("alias hits", xram_hits, 1);
    cpu_acc(0, 0, 16'h0005, 0, d); chk("alias data", d, 8'h5a);
    // split without bank select, separate pins
    ahb(1, 8'h00, 32'h14, r);
    ahb(1, 8'h04, 32'h20, r);
    port_hi = 8'h20;
    cpu_acc(1, 1, 16'h0033, 8'h77, d); chk("upper released", hi_drv, 0);
    chk("no latch strobe", hi_len, 0);
    cpu_acc(1, 0, 16'h0033, 0, d); chk("sep read", d, 8'h77);
    chk("off-chip hits", xram_hits, 0);
    cpu_acc(0, 1, 16'h0fff, 8'h11, d); chk("below boundary", xram_hits, 1);
    cpu_acc(0, 1, 16'h1000, 8'h22, d); chk("at boundary", xram_hits, 0);
    chk("16-bit upper", hi_seen, 8'h10);
    // bank select, multiplexed, every pulse width code
    mux_mode = 1'b0;
    port_hi = 8'h99;
    ahb(1, 8'h04, 32'h40, r);
    for (int w = 0; w < 4; w++) begin
      ahb(1, 8'h00, 32'h08 | w, r);
      cpu_acc(1, 1, 16'(w), 8'(8'h80 + w), d); chk("ale high", hi_len, w + 1);
      chk("ale low", lo_len, w + 1);
      chk("page byte", hi_seen, 8'h40);
      cpu_acc(1, 0, 16'(w), 0, d); chk("mux read", d, 8'h80 + w);
    end
    // width code ignored with separate pins
    mux_mode = 1'b1;
    ahb(1, 8'h00, 32'h1b, r);
    cpu_acc(1, 1, 16'h0001, 8'h44, d); chk("width ignored", hi_len, 0);
    // external only: low addresses go off-chip
    mux_mode = 1'b0;
    ahb(1, 8'h00, 32'h0c, r);
    cpu_acc(0, 1, 16'h0010, 8'h3c, d); chk("ext hits", xram_hits, 0);
    cpu_acc(0, 0, 16'h0010, 0, d); chk("ext read", d, 8'h3c);
    ahb(0, 8'h08, 0, r); chk("status", r, 32'h0c);
    end_of_test();
  end
endmodule
`default_nettype wire
